// ===== src/ipvc_pkg.sv
// Shared constants and types of the ingress port VLAN classifier
package ipvc_pkg;
	localparam int PORTS = 53;
	localparam int RULES = 16;
	localparam int PORT_W = 6;
	localparam int VID_W = 12;
	localparam int PCP_W = 3;
	localparam int SEL_W = 2;
	localparam int STP_W = 3;
	localparam int OP_W = 3;
	localparam int PREF_W = 3;
	localparam int TPID_W = 16;
	localparam int WORD_W = 32;
	localparam int CFG_W = 94;
	localparam int RULE_W = 19;
	localparam int CMPV_W = 9;
	// Port configuration entry, field low bits
	localparam int F_OP = 24;
	localparam int F_VIDSRC = 27;
	localparam int F_DEISRC = 29;
	localparam int F_PCPSRC = 31;
	localparam int F_TPIDSRC = 33;
	localparam int F_VIDMODE = 35;
	localparam int F_DEFVID = 37;
	localparam int F_DEFDEI = 49;
	localparam int F_DEFPCP = 50;
	localparam int F_PREC = 53;
	localparam int F_MINTAG = 55;
	localparam int F_MAXTAG = 57;
	localparam int F_SKIPMEM = 59;
	localparam int F_LRNGRP = 60;
	localparam int F_LRNEQ = 61;
	localparam int F_COPYON = 62;
	localparam int F_COPYMEM = 63;
	localparam int F_COPYISO = 64;
	localparam int F_COPYTGT = 65;
	localparam int F_STP = 71;
	localparam int F_PRIOON = 74;
	localparam int F_PRIOID = 75;
	localparam int F_L2ON = 87;
	localparam int F_L2FLAG = 88;
	localparam int F_FBON = 89;
	localparam int F_OVR = 90;
	localparam int F_PREF = 91;
	// Attack rule fields
	localparam int R_VAL = 0;
	localparam int R_CMP = 9;
	localparam int R_EN = 18;
	// Reset entry: spanning tree disabled so no learning, max tags any, learn when addresses equal
	localparam logic [CFG_W-1:0] CFG_RST = 94'h0000_2400_0000_0000_0001;
	localparam logic [RULE_W-1:0] RULE_RST = 19'h0_0000;
	localparam logic [TPID_W-1:0] TPID_C = 16'h8100;
	localparam logic [TPID_W-1:0] TPID_S = 16'h88a8;
	localparam logic [TPID_W-1:0] TPID_USER_RST = 16'h8100;
	// Header source selectors, also the VID assignment modes
	localparam logic [SEL_W-1:0] SRC_OUTER = 2'h0;
	localparam logic [SEL_W-1:0] SRC_DEFAULT = 2'h1;
	localparam logic [SEL_W-1:0] SRC_INNER = 2'h2;
	localparam logic [SEL_W-1:0] TP_C = 2'h0;
	localparam logic [SEL_W-1:0] TP_S = 2'h1;
	localparam logic [SEL_W-1:0] TP_USER = 2'h2;
	// Tag counts and tag limit codes
	localparam logic [1:0] CNT_ZERO = 2'h0;
	localparam logic [1:0] CNT_ONE = 2'h1;
	localparam logic [1:0] CNT_TWO = 2'h2;
	localparam logic [1:0] LIM_ZERO = 2'h0;
	localparam logic [1:0] LIM_ONE = 2'h1;
	localparam logic [1:0] LIM_TWO = 2'h2;
	localparam logic [1:0] LIM_NONE = 2'h3;
	typedef enum logic [OP_W-1:0] {
		OP_NONE = 3'h0, OP_SWAP = 3'h1, OP_PUSH = 3'h2, OP_POP = 3'h3, OP_POP_ALL = 3'h4
	} ipvc_op_type;
	typedef enum logic [STP_W-1:0] {
		STP_DISABLED = 3'h0, STP_BLOCKING = 3'h1, STP_LISTENING = 3'h2,
		STP_LEARNING = 3'h3, STP_FORWARDING = 3'h4
	} ipvc_stp_type;
	// Byte addresses on the register bus
	localparam logic [31:0] RULE_IDX = 32'h0004_1191;
	localparam logic [31:0] RULE_BASE = RULE_IDX << 2;
	localparam logic [31:0] RULE_END = RULE_BASE + 32'(RULES * 4);
	localparam logic [31:0] PORT_BASE = 32'h0001_0000;
	localparam logic [31:0] PORT_END = PORT_BASE + 32'(PORTS * 16);
	localparam logic [31:0] TPID_ADDR = 32'h0002_0000;
	localparam logic [31:0] CNT_MIN_ADDR = 32'h0002_0010;
	localparam logic [31:0] CNT_MAX_ADDR = 32'h0002_0014;
	localparam logic [31:0] CNT_MEM_ADDR = 32'h0002_0018;
	localparam logic [31:0] CNT_ATK_ADDR = 32'h0002_001c;
endpackage

// ===== src/ipvc_tag_build.sv
// Header field selection for pushed or swapped tags and ingress VID
`timescale 1ns/10ps
`default_nettype none
module ipvc_tag_build import ipvc_pkg::*; (
	// Selectors
	input wire logic [SEL_W-1:0] vid_src,
	input wire logic [SEL_W-1:0] dei_src,
	input wire logic [SEL_W-1:0] pcp_src,
	input wire logic [SEL_W-1:0] tpid_src,
	input wire logic [SEL_W-1:0] vid_mode,
	// Packet tags and port defaults
	input wire logic [1:0] tag_cnt,
	input wire logic [VID_W-1:0] outer_vid,
	input wire logic outer_dei,
	input wire logic [PCP_W-1:0] outer_pcp,
	input wire logic [VID_W-1:0] inner_vid,
	input wire logic inner_dei,
	input wire logic [PCP_W-1:0] inner_pcp,
	input wire logic [VID_W-1:0] def_vid,
	input wire logic def_dei,
	input wire logic [PCP_W-1:0] def_pcp,
	input wire logic [TPID_W-1:0] user_tpid,
	// Results
	output logic [VID_W-1:0] new_vid,
	output logic new_dei,
	output logic [PCP_W-1:0] new_pcp,
	output logic [TPID_W-1:0] new_tpid,
	output logic [VID_W-1:0] assign_vid
);
	// Falls back to the default when the chosen tag is absent
	function automatic logic [SEL_W-1:0] pick(input logic [SEL_W-1:0] sel, input logic [1:0] cnt);
		case (sel)
			SRC_OUTER: pick = (cnt >= CNT_ONE) ? SRC_OUTER : SRC_DEFAULT;
			SRC_INNER: pick = (cnt >= CNT_TWO) ? SRC_INNER : SRC_DEFAULT;
			default: pick = SRC_DEFAULT;
		endcase
	endfunction

	function automatic logic [VID_W-1:0] vid_of(input logic [SEL_W-1:0] s, input logic [VID_W-1:0] o,
		input logic [VID_W-1:0] i, input logic [VID_W-1:0] d);
		case (s)
			SRC_OUTER: vid_of = o;
			SRC_INNER: vid_of = i;
			default: vid_of = d;
		endcase
	endfunction

	// VID modes share the selector encoding, code 3 reads as default
	always_comb begin
		new_vid = vid_of(pick(vid_src, tag_cnt), outer_vid, inner_vid, def_vid);
		assign_vid = vid_of(pick(vid_mode, tag_cnt), outer_vid, inner_vid, def_vid);
		case (pick(dei_src, tag_cnt))
			SRC_OUTER: new_dei = outer_dei;
			SRC_INNER: new_dei = inner_dei;
			default: new_dei = def_dei;
		endcase
		case (pick(pcp_src, tag_cnt))
			SRC_OUTER: new_pcp = outer_pcp;
			SRC_INNER: new_pcp = inner_pcp;
			default: new_pcp = def_pcp;
		endcase
		// Code 3 is undefined, so it falls back to the customer TPID
		case (tpid_src)
			TP_S: new_tpid = TPID_S;
			TP_USER: new_tpid = user_tpid;
			default: new_tpid = TPID_C;
		endcase
	end
endmodule
`default_nettype wire

// ===== src/ipvc_attack_match.sv
// Parallel TCP/UDP flag attack rule matcher
`timescale 1ns/10ps
`default_nettype none
module ipvc_attack_match import ipvc_pkg::*; #(
	parameter int N = RULES
) (
	// Rule table and packet status
	input wire logic [RULE_W-1:0] rules [N],
	input wire logic [CMPV_W-1:0] pkt,
	input wire logic check,
	// Any enabled rule matched
	output logic hit
);
	if (N < 1) begin : g_chk
		$error("ipvc_attack_match needs at least one rule");
	end

	// Enabled rule with no compares matches every checked packet
	always_comb begin
		hit = 1'b0;
		for (int i = 0; i < N; i++) begin
			if (rules[i][R_EN] &&
				((rules[i][R_VAL +: CMPV_W] ^ pkt) & rules[i][R_CMP +: CMPV_W]) == '0) begin
				hit = 1'b1;
			end
		end
		hit = hit & check;
	end
endmodule
`default_nettype wire

// ===== src/ipvc_classifier.sv
// Ingress port VLAN classifier with AHB-Lite register access
// Contract
// - Pushed VID from outer tag, port default or second tag; default if absent.
// - Pushed DEI from outer tag, port default or second tag; default if absent.
// - Pushed PCP from outer tag, port default or second tag; default if absent.
// - Pushed TPID is 0x8100, 0x88A8 or the user TPID register.
// - Ingress VID from outer tag, port default, or inner of two tags.
// - Port default VID, DEI and PCP form the header of untagged packets.
// - A range hit replaces the VID only above the port precedence.
// - Minimum tag count check drops and counts failing packets.
// - Maximum tag count check drops and counts failing packets.
// - Non-member source ports drop unless the skip bit is set.
// - Group source addresses are learned only with the group bit set.
// - Equal source and destination addresses skip learning when bit clear.
// - Ingress copy goes unmodified to the configured target port.
// - Copy is suppressed by membership or isolation when enabled.
// - Per-port spanning tree state gates forwarding and learning.
// - Priority tag gives the queue PCP, is not a tag, strips on egress.
// - L2 action lookup enable and port flag pass to the action tables.
// - Port default rule action applies on an ACL miss when enabled.
// - Override bit applies the port rule action on hit or miss.
// - Per-port prefilter bits go to every prefilter lookup.
// - IP TCP/UDP packets matching any enabled rule drop and count.
// - Rule holds flag, address-equal and port-equal compare values.
// - Per-port tag operation code none, swap, push, pop, pop all.
//
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module ipvc_classifier import ipvc_pkg::*; #(
	parameter int CNT_W = 32
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Packet descriptor from the parser
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [PORT_W-1:0] in_src_port,
	input wire logic [1:0] in_tag_cnt,
	input wire logic [VID_W-1:0] in_outer_vid,
	input wire logic in_outer_dei,
	input wire logic [PCP_W-1:0] in_outer_pcp,
	input wire logic in_outer_at_mac,
	input wire logic [VID_W-1:0] in_inner_vid,
	input wire logic in_inner_dei,
	input wire logic [PCP_W-1:0] in_inner_pcp,
	input wire logic in_src_member,
	input wire logic in_copy_member,
	input wire logic in_copy_isolated,
	input wire logic in_sa_group,
	input wire logic in_da_eq_sa,
	input wire logic in_range_hit,
	input wire logic [VID_W-1:0] in_range_vid,
	input wire logic [1:0] in_range_order,
	input wire logic in_acl_hit,
	input wire logic in_ip_l4,
	input wire logic [5:0] in_l4_flags,
	input wire logic in_ip_addr_equal,
	input wire logic in_tcp_port_equal,
	input wire logic in_udp_port_equal,
	// Classification result
	output logic out_valid,
	input wire logic out_ready,
	output logic out_drop,
	output logic out_drop_min,
	output logic out_drop_max,
	output logic out_drop_member,
	output logic out_drop_attack,
	output logic [VID_W-1:0] out_ingress_vid,
	output logic out_int_dei,
	output logic [PCP_W-1:0] out_int_pcp,
	output logic [PCP_W-1:0] out_queue_pcp,
	output logic out_prio_strip,
	output ipvc_op_type out_tag_op,
	output logic [VID_W-1:0] out_new_vid,
	output logic out_new_dei,
	output logic [PCP_W-1:0] out_new_pcp,
	output logic [TPID_W-1:0] out_new_tpid,
	output logic out_learn_ok,
	output logic out_copy_valid,
	output logic [PORT_W-1:0] out_copy_port,
	output ipvc_stp_type out_stp_state,
	output logic out_stp_forward,
	output logic out_stp_learn,
	output logic out_l2_lookup,
	output logic out_l2_flag,
	output logic out_use_port_rule,
	output logic [PREF_W-1:0] out_prefilter
);
	if (CNT_W < 1 || CNT_W > WORD_W) begin : g_chk
		$error("ipvc_classifier counter width must be 1 to 32");
	end

	logic [CFG_W-1:0] cfg_q [PORTS];
	logic [RULE_W-1:0] rule_q [RULES];
	logic [TPID_W-1:0] tpid_q;
	logic [CNT_W-1:0] cnt_min_q, cnt_max_q, cnt_mem_q, cnt_atk_q;
	logic wr_q;
	logic [31:0] wa_q;
	logic [31:0] rd_d;
	logic [31:0] hrdata_q;
	logic a_act;

	function automatic logic is_port(input logic [31:0] a);
		is_port = (a >= PORT_BASE) && (a < PORT_END);
	endfunction

	function automatic logic [PORT_W-1:0] port_of(input logic [31:0] a);
		logic [31:0] off;
		off = a - PORT_BASE;
		port_of = off[PORT_W+3:4];
	endfunction

	function automatic logic is_rule(input logic [31:0] a);
		is_rule = (a >= RULE_BASE) && (a < RULE_END);
	endfunction

	function automatic logic [3:0] rule_of(input logic [31:0] a);
		logic [31:0] off;
		off = a - RULE_BASE;
		rule_of = off[5:2];
	endfunction

	// Zero wait state slave, every answer OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_q;
	assign a_act = hsel && hready && htrans[1];

	// Address phase capture for the write data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q <= 1'b0;
			wa_q <= '0;
		end else begin
			wr_q <= a_act && hwrite;
			wa_q <= haddr;
		end
	end

	// Read mux; unmapped and reserved space reads zero
	always_comb begin
		rd_d = '0;
		if (is_port(haddr)) begin
			case (haddr[3:2])
				2'h0: rd_d = cfg_q[port_of(haddr)][WORD_W-1:0];
				2'h1: rd_d = cfg_q[port_of(haddr)][2*WORD_W-1:WORD_W];
				2'h2: rd_d = 32'(cfg_q[port_of(haddr)][CFG_W-1:2*WORD_W]);
				default: rd_d = '0;
			endcase
		end else if (is_rule(haddr)) begin
			rd_d = 32'(rule_q[rule_of(haddr)]);
		end else begin
			case (haddr)
				TPID_ADDR: rd_d = 32'(tpid_q);
				CNT_MIN_ADDR: rd_d = 32'(cnt_min_q);
				CNT_MAX_ADDR: rd_d = 32'(cnt_max_q);
				CNT_MEM_ADDR: rd_d = 32'(cnt_mem_q);
				CNT_ATK_ADDR: rd_d = 32'(cnt_atk_q);
				default: rd_d = '0;
			endcase
		end
	end

	// Read data registered for the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_q <= '0;
		end else if (a_act && !hwrite) begin
			hrdata_q <= rd_d;
		end
	end

	// Port configuration table writes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < PORTS; i++) begin
				cfg_q[i] <= CFG_RST;
			end
		end else if (wr_q && is_port(wa_q)) begin
			case (wa_q[3:2])
				2'h0: cfg_q[port_of(wa_q)][WORD_W-1:0] <= hwdata;
				2'h1: cfg_q[port_of(wa_q)][2*WORD_W-1:WORD_W] <= hwdata;
				2'h2: cfg_q[port_of(wa_q)][CFG_W-1:2*WORD_W] <= hwdata[CFG_W-2*WORD_W-1:0];
				default: ;
			endcase
		end
	end

	// Attack rules and user TPID writes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < RULES; i++) begin
				rule_q[i] <= RULE_RST;
			end
			tpid_q <= TPID_USER_RST;
		end else if (wr_q) begin
			if (is_rule(wa_q)) begin
				rule_q[rule_of(wa_q)] <= hwdata[RULE_W-1:0];
			end else if (wa_q == TPID_ADDR) begin
				tpid_q <= hwdata[TPID_W-1:0];
			end
		end
	end

	// Per-packet view of the source port entry
	logic [CFG_W-1:0] c;
	logic take, prio_tag;
	logic [1:0] eff_cnt;
	logic [VID_W-1:0] eff_ovid, b_vid, new_vid, asg_vid;
	logic eff_odei, new_dei;
	logic [PCP_W-1:0] eff_opcp, new_pcp;
	logic [TPID_W-1:0] new_tpid;
	logic min_fail, max_fail, mem_fail, atk_hit;
	logic [SEL_W-1:0] min_c, max_c;

	// Out-of-range port numbers see the reset entry
	assign c = (in_src_port < PORT_W'(PORTS)) ? cfg_q[in_src_port] : CFG_RST;
	assign take = in_valid && in_ready;
	assign in_ready = !out_valid || out_ready;
	assign min_c = c[F_MINTAG +: SEL_W];
	assign max_c = c[F_MAXTAG +: SEL_W];

	// Priority tag is dropped from the tag stack seen by later stages
	assign prio_tag = c[F_PRIOON] && in_outer_at_mac && (in_tag_cnt >= CNT_ONE) &&
		(in_outer_vid == c[F_PRIOID +: VID_W]);
	assign eff_cnt = prio_tag ? in_tag_cnt - CNT_ONE : in_tag_cnt;
	assign eff_ovid = prio_tag ? in_inner_vid : in_outer_vid;
	assign eff_odei = prio_tag ? in_inner_dei : in_outer_dei;
	assign eff_opcp = prio_tag ? in_inner_pcp : in_outer_pcp;

	ipvc_tag_build u_build (
		.vid_src(c[F_VIDSRC +: SEL_W]),
		.dei_src(c[F_DEISRC +: SEL_W]),
		.pcp_src(c[F_PCPSRC +: SEL_W]),
		.tpid_src(c[F_TPIDSRC +: SEL_W]),
		.vid_mode(c[F_VIDMODE +: SEL_W]),
		.tag_cnt(eff_cnt),
		.outer_vid(eff_ovid),
		.outer_dei(eff_odei),
		.outer_pcp(eff_opcp),
		.inner_vid(in_inner_vid),
		.inner_dei(in_inner_dei),
		.inner_pcp(in_inner_pcp),
		.def_vid(c[F_DEFVID +: VID_W]),
		.def_dei(c[F_DEFDEI]),
		.def_pcp(c[F_DEFPCP +: PCP_W]),
		.user_tpid(tpid_q),
		.new_vid(new_vid),
		.new_dei(new_dei),
		.new_pcp(new_pcp),
		.new_tpid(new_tpid),
		.assign_vid(asg_vid)
	);

	ipvc_attack_match #(.N(RULES)) u_attack (
		.rules(rule_q),
		.pkt({in_udp_port_equal, in_tcp_port_equal, in_ip_addr_equal, in_l4_flags}),
		.check(in_ip_l4),
		.hit(atk_hit)
	);

	// Admission checks on the tag stack after priority tag removal
	always_comb begin
		case (min_c)
			LIM_ONE: min_fail = eff_cnt < CNT_ONE;
			LIM_TWO: min_fail = eff_cnt < CNT_TWO;
			LIM_NONE: min_fail = 1'b1;
			default: min_fail = 1'b0;
		endcase
		case (max_c)
			LIM_ZERO: max_fail = eff_cnt != CNT_ZERO;
			LIM_ONE: max_fail = eff_cnt > CNT_ONE;
			default: max_fail = 1'b0;
		endcase
		mem_fail = !in_src_member && !c[F_SKIPMEM];
		// Range hit wins only with strictly higher order
		if (in_range_hit && (in_range_order > c[F_PREC +: SEL_W])) begin
			b_vid = in_range_vid;
		end else begin
			b_vid = asg_vid;
		end
	end

	// Result register; holds while the pipeline stalls
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			out_valid <= 1'b0;
		end else if (in_ready) begin
			out_valid <= in_valid;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			out_drop <= 1'b0;
			out_drop_min <= 1'b0;
			out_drop_max <= 1'b0;
			out_drop_member <= 1'b0;
			out_drop_attack <= 1'b0;
			out_ingress_vid <= '0;
			out_int_dei <= 1'b0;
			out_int_pcp <= '0;
			out_queue_pcp <= '0;
			out_prio_strip <= 1'b0;
			out_tag_op <= OP_NONE;
			out_new_vid <= '0;
			out_new_dei <= 1'b0;
			out_new_pcp <= '0;
			out_new_tpid <= TPID_C;
			out_learn_ok <= 1'b0;
			out_copy_valid <= 1'b0;
			out_copy_port <= '0;
			out_stp_state <= STP_DISABLED;
			out_stp_forward <= 1'b0;
			out_stp_learn <= 1'b0;
			out_l2_lookup <= 1'b0;
			out_l2_flag <= 1'b0;
			out_use_port_rule <= 1'b0;
			out_prefilter <= '0;
		end else if (take) begin
			out_drop <= min_fail || max_fail || mem_fail || atk_hit;
			out_drop_min <= min_fail;
			out_drop_max <= max_fail;
			out_drop_member <= mem_fail;
			out_drop_attack <= atk_hit;
			out_ingress_vid <= b_vid;
			// Untagged packets get an internal header from the port defaults
			out_int_dei <= (eff_cnt == CNT_ZERO) ? c[F_DEFDEI] : eff_odei;
			out_int_pcp <= (eff_cnt == CNT_ZERO) ? c[F_DEFPCP +: PCP_W] : eff_opcp;
			out_queue_pcp <= prio_tag ? in_outer_pcp :
				(eff_cnt == CNT_ZERO) ? c[F_DEFPCP +: PCP_W] : eff_opcp;
			out_prio_strip <= prio_tag;
			out_tag_op <= ipvc_op_type'(c[F_OP +: OP_W]);
			out_new_vid <= new_vid;
			out_new_dei <= new_dei;
			out_new_pcp <= new_pcp;
			out_new_tpid <= new_tpid;
			out_learn_ok <= !(in_sa_group && !c[F_LRNGRP]) &&
				!(in_da_eq_sa && !c[F_LRNEQ]);
			// Copy is a request; downstream applies the usual resource limits
			out_copy_valid <= c[F_COPYON] &&
				!(c[F_COPYMEM] && !in_copy_member) && !(c[F_COPYISO] && in_copy_isolated);
			out_copy_port <= c[F_COPYTGT +: PORT_W];
			out_stp_state <= ipvc_stp_type'(c[F_STP +: STP_W]);
			out_stp_forward <= c[F_STP +: STP_W] == STP_DISABLED ||
				c[F_STP +: STP_W] == STP_FORWARDING;
			out_stp_learn <= c[F_STP +: STP_W] == STP_LEARNING ||
				c[F_STP +: STP_W] == STP_FORWARDING;
			out_l2_lookup <= c[F_L2ON];
			out_l2_flag <= c[F_L2FLAG];
			out_use_port_rule <= c[F_OVR] || (c[F_FBON] && !in_acl_hit);
			out_prefilter <= c[F_PREF +: PREF_W];
		end
	end

	// Drop counters wrap; one packet may count in several
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_min_q <= '0;
			cnt_max_q <= '0;
			cnt_mem_q <= '0;
			cnt_atk_q <= '0;
		end else if (take) begin
			cnt_min_q <= cnt_min_q + CNT_W'(min_fail);
			cnt_max_q <= cnt_max_q + CNT_W'(max_fail);
			cnt_mem_q <= cnt_mem_q + CNT_W'(mem_fail);
			cnt_atk_q <= cnt_atk_q + CNT_W'(atk_hit);
		end
	end

	// Checks on the classification path
	min_tag_a: assert property (@(posedge hclk) disable iff (!hresetn)
		take && min_c == LIM_TWO && eff_cnt == CNT_ONE |=> out_valid && out_drop && out_drop_min)
		else $error("minimum tag drop missing");
	max_tag_a: assert property (@(posedge hclk) disable iff (!hresetn)
		take && max_c == LIM_ZERO && eff_cnt != CNT_ZERO |=> out_drop && out_drop_max)
		else $error("maximum tag drop missing");
	min_count_a: assert property (@(posedge hclk) disable iff (!hresetn)
		take && min_fail |=> cnt_min_q == $past(cnt_min_q) + CNT_W'(1))
		else $error("minimum tag counter not incremented");
	member_skip_a: assert property (@(posedge hclk) disable iff (!hresetn)
		take && !in_src_member |=> out_drop_member == !$past(c[F_SKIPMEM]))
		else $error("membership drop wrong");
	attack_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
		take && !in_ip_l4 |=> !out_drop_attack && cnt_atk_q == $past(cnt_atk_q))
		else $error("non TCP/UDP packet flagged as attack");
	rule_force_a: assert property (@(posedge hclk) disable iff (!hresetn)
		take && c[F_OVR] && in_acl_hit |=> out_use_port_rule)
		else $error("forced port rule not applied");
	copy_iso_a: assert property (@(posedge hclk) disable iff (!hresetn)
		take && c[F_COPYISO] && in_copy_isolated |=> !out_copy_valid)
		else $error("isolated copy not suppressed");
	learn_equal_a: assert property (@(posedge hclk) disable iff (!hresetn)
		take && in_da_eq_sa && !c[F_LRNEQ] |=> !out_learn_ok)
		else $error("learning not discarded");
	vid_prec_a: assert property (@(posedge hclk) disable iff (!hresetn)
		take && in_range_hit && in_range_order <= c[F_PREC +: SEL_W] |=>
		out_ingress_vid == $past(asg_vid))
		else $error("range hit overrode precedence");
	tpid_std_a: assert property (@(posedge hclk) disable iff (!hresetn)
		take && c[F_TPIDSRC +: SEL_W] == TP_S |=> out_new_tpid == TPID_S)
		else $error("service TPID not selected");
	stall_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
		out_valid && !out_ready |=> out_valid && $stable(out_ingress_vid) && $stable(out_drop))
		else $error("result changed under back-pressure");

	drop_seen_c: cover property (@(posedge hclk) disable iff (!hresetn) out_valid && out_drop);
	copy_seen_c: cover property (@(posedge hclk) disable iff (!hresetn) out_valid && out_copy_valid);
	attack_seen_c: cover property (@(posedge hclk) disable iff (!hresetn) take && atk_hit);
	stall_seen_c: cover property (@(posedge hclk) disable iff (!hresetn)
		out_valid && !out_ready ##1 out_ready);
endmodule
`default_nettype wire

// ===== verif/ipvc_sink.sv
// Result consumer model of the forwarding pipeline
`timescale 1ns/10ps
`default_nettype none
module ipvc_sink (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Result handshake
	input wire logic out_valid,
	output logic out_ready
);
	logic [1:0] cyc_q;
	// Stall one result cycle in four so results must stand
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) cyc_q <= '0;
		else if (out_valid) cyc_q <= cyc_q + 2'h1;
	end
	assign out_ready = cyc_q != 2'h3;
endmodule
`default_nettype wire

// ===== verif/ipvc_classifier_tb.sv
// Self-checking bench of the classifier
`timescale 1ns/10ps
`default_nettype none
module ipvc_classifier_tb import ipvc_pkg::*;;
	logic hclk='0, hresetn='0, hsel='0, hwrite='0, in_valid='0, in_outer_dei='0, in_outer_at_mac='0;
	logic in_inner_dei='0, in_src_member=1'h1, in_copy_member='0, in_copy_isolated='0;
	logic in_sa_group='0, in_da_eq_sa='0, in_range_hit='0, in_acl_hit='0, in_ip_l4='0;
	logic in_ip_addr_equal='0, in_tcp_port_equal='0, in_udp_port_equal='0;
	logic [31:0] haddr='0, hwdata='0, rd_q;
	logic [1:0] htrans='0, in_tag_cnt='0, in_range_order='0;
	logic [2:0] hsize=3'h2, in_outer_pcp='0, in_inner_pcp='0;
	logic [5:0] in_src_port='0, in_l4_flags='0;
	logic [11:0] in_outer_vid=12'h123, in_inner_vid='0, in_range_vid='0;
	wire logic hready, hreadyout, hresp, in_ready, out_valid, out_ready, out_drop, out_drop_min;
	wire logic out_drop_max, out_drop_member, out_drop_attack, out_int_dei, out_prio_strip;
	wire logic out_new_dei, out_learn_ok, out_copy_valid, out_stp_forward, out_stp_learn;
	wire logic out_l2_lookup, out_l2_flag, out_use_port_rule;
	wire logic [31:0] hrdata;
	wire logic [11:0] out_ingress_vid, out_new_vid;
	wire logic [2:0] out_int_pcp, out_queue_pcp, out_new_pcp, out_prefilter;
	wire logic [15:0] out_new_tpid;
	wire logic [5:0] out_copy_port;
	wire ipvc_op_type out_tag_op;
	wire ipvc_stp_type out_stp_state;
	int err_count = 0, n_compared = 0;
	assign hready = hreadyout;
	ipvc_classifier dut_u (.*);
	ipvc_sink sink_u (.hclk(hclk), .hresetn(hresetn), .out_valid(out_valid), .out_ready(out_ready));
	always #10 hclk = ~hclk;
	task automatic end_of_test;
		$display("errors %0d compared %0d", err_count, n_compared);
		if (err_count == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			err_count++;
			$display("MISMATCH %s exp %h seen %h", n, e, s);
		end
	endtask
	// Bounded wait: 0 bus ready, 1 descriptor taken, 2 result handed over
	// Condition is read before the edge, as the design sees it at that edge
	task automatic wt(input int k);
		logic ok;
		for (int i = 0; i < 40; i++) begin
			@(negedge hclk);
			ok = (k == 0 ? hready : k == 1 ? in_ready : out_valid & out_ready) === 1'h1;
			@(posedge hclk);
			if (ok) return;
		end
		err_count++;
		end_of_test();
	endtask
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'h1; htrans <= 2'h2; haddr <= a; hwrite <= w;
		wt(0);
		hsel <= 1'h0; htrans <= 2'h0; hwdata <= d;
		wt(0);
		rd_q = hrdata;
	endtask
	task automatic rc(input logic [31:0] a, input logic [31:0] e);
		bus(1'h0, a, '0);
		chk("reg", rd_q, e);
	endtask
	task automatic pkt(input logic [1:0] t, input logic l4, input logic [5:0] f);
		in_tag_cnt <= t; in_ip_l4 <= l4; in_l4_flags <= f; in_valid <= 1'h1;
		wt(1);
		in_valid <= 1'h0;
		wt(2);
	endtask
	// Reset entry, user TPID and an unmapped hole
	task automatic t_reset;
		rc(PORT_BASE, 32'h0000_0001);
		rc(PORT_BASE + 32'h0000_0004, 32'h2400_0000);
		rc(TPID_ADDR, 32'h0000_8100);
		rc(32'h0003_0000, 32'h0000_0000);
	endtask
	// Tag count limits at their strictest useful codes
	task automatic t_tags;
		bus(1'h1, PORT_BASE + 32'h0000_0004, 32'h2500_0000);
		pkt(2'h1, 1'h0, '0);
		chk("min", out_drop_min, 1'h1);
		bus(1'h1, PORT_BASE + 32'h0000_0004, 32'h2000_0000);
		pkt(2'h1, 1'h0, '0);
		chk("max", out_drop_max, 1'h1);
		rc(CNT_MIN_ADDR, 32'h0000_0001);
		rc(CNT_MAX_ADDR, 32'h0000_0001);
	endtask
	// Push with port default VID and S-tag, port based VID
	task automatic t_push;
		bus(1'h1, PORT_BASE, 32'h0a00_0001);
		bus(1'h1, PORT_BASE + 32'h0000_0004, 32'h2400_b4aa);
		pkt(2'h1, 1'h0, '0);
		chk("vid", out_ingress_vid, 12'h5a5);
		chk("nvid", out_new_vid, 12'h5a5);
		chk("tpid", out_new_tpid, TPID_S);
		chk("op", out_tag_op, OP_PUSH);
	endtask
	// SYN rule hits SYN only, counter follows
	task automatic t_attack;
		bus(1'h1, RULE_BASE, 32'h0004_2010);
		pkt(2'h1, 1'h1, 6'h10);
		chk("atk", out_drop_attack, 1'h1);
		pkt(2'h1, 1'h1, 6'h00);
		chk("noatk", out_drop_attack, 1'h0);
		rc(CNT_ATK_ADDR, 32'h0000_0001);
	endtask
	// Priority tag, non-member source, copy, spanning tree, forced rule
	task automatic t_misc;
		in_src_member <= 1'h0; in_da_eq_sa <= 1'h1; in_acl_hit <= 1'h1; in_range_hit <= 1'h1;
		in_outer_at_mac <= 1'h1; in_outer_pcp <= 3'h6; in_inner_vid <= 12'h456; in_inner_dei <= 1'h1;
		bus(1'h1, PORT_BASE + 32'h0000_0004, 32'h4400_0000);
		bus(1'h1, PORT_BASE + 32'h0000_0008, 32'h2d89_1e0a);
		pkt(2'h2, 1'h0, '0);
		chk("mem", {out_drop, out_drop_member}, 2'h3);
		chk("lrn", out_learn_ok, 1'h0);
		chk("copy", {out_copy_valid, out_copy_port}, 7'h45);
		chk("stp", {out_stp_forward, out_stp_learn, out_stp_state}, 5'h1c);
		chk("l2", {out_l2_lookup, out_l2_flag, out_use_port_rule}, 3'h7);
		chk("pref", out_prefilter, 3'h5);
		chk("pvid", out_ingress_vid, 12'h456);
		chk("pcp", {out_prio_strip, out_int_pcp, out_queue_pcp, out_new_pcp}, 10'h230);
		chk("dei", {out_int_dei, out_new_dei}, 2'h3);
	endtask
	initial begin
		repeat (6) @(posedge hclk);
		hresetn <= 1'h1;
		@(posedge hclk);
		t_reset();
		t_tags();
		t_push();
		t_attack();
		t_misc();
		end_of_test();
	end
endmodule
`default_nettype wire
